// file: core/cfg_regs_pkg.sv
// Register map, field positions and shared types of the I2C configuration register file.
package cfg_regs_pkg;
  localparam logic [6:0] BOARD_ADDR = 7'h00;
  localparam logic [7:0] OFF_LANE = 8'h00;
  localparam logic [7:0] OFF_SUMMARY = 8'h01;
  localparam logic [7:0] OFF_SLOT_EN = 8'h02;
  localparam logic [7:0] OFF_ALIGN = 8'h03;
  localparam logic [7:0] OFF_TEMP = 8'h04;
  localparam logic [7:0] OFF_VOLT = 8'h05;
  localparam logic [7:0] OFF_CMD = 8'h06;
  localparam logic [7:0] OFF_ERASE = 8'h07;
  localparam logic [7:0] OFF_SDATA = 8'h08;
  localparam logic [7:0] OFF_SADDR_LO = 8'h09;
  localparam logic [7:0] OFF_SCTRL = 8'h0A;
  localparam logic [7:0] OFF_SREAD = 8'h0B;
  localparam logic [7:0] OFF_IDLE_VER = 8'h11;
  localparam int N_SLOTS = 5;
  localparam int N_LANES = 10;
  localparam int SLOT_EN_LSB = 6;
  localparam int ALIGN_ARM_BIT = 3;
  localparam int INIT_BIT = 1;
  localparam int TGT_LSB = 9;
  localparam int EXEC_BIT = 8;
  localparam int SRAM_SEL_BIT = 7;
  localparam int OPC_LSB = 3;
  localparam int SWR_BIT = 15;
  localparam int SRD_BIT = 14;
  localparam int ADDR_HI_W = 6;
  localparam int ERASE_W = 10;
  localparam int SRAM_ADDR_W = 22;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] SLOT_EN_MASK = 16'h5540;
  localparam logic [15:0] ALIGN_MASK = 16'h000A;
  localparam logic [15:0] CMD_MASK = 16'h07F8;
  localparam logic [15:0] ERASE_MASK = 16'h03FF;
  localparam logic [15:0] SCTRL_MASK = 16'hC03F;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] PIN_IDLE = 3'b011;
  localparam logic [3:0] OPC_READ = 4'h3;
  localparam logic [3:0] OPC_IDENT = 4'h6;
  localparam logic [3:0] OPC_ERASE = 4'h9;
  localparam logic [3:0] OPC_UNUSED = 4'hC;
  localparam logic [3:0] FPGA_COUNT = 4'h3;

  typedef enum logic [2:0] {OP_PROGRAM, OP_READ, OP_IDENT, OP_ERASE, OP_NONE} op_class_t;
  typedef enum logic [3:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_ADDR, I2C_SUB, I2C_ACK_SUB,
    I2C_WDATA, I2C_ACK_W, I2C_RDATA, I2C_ACK_R
  } i2c_state_t;

  function automatic op_class_t decode_op(input logic [3:0] opc);
    if (opc < OPC_READ) return OP_PROGRAM;
    else if (opc < OPC_IDENT) return OP_READ;
    else if (opc < OPC_ERASE) return OP_IDENT;
    else if (opc < OPC_UNUSED) return OP_ERASE;
    else return OP_NONE;
  endfunction

  // Opcodes come in groups of three; the position in the group names the FPGA, 1 to 3.
  function automatic logic [1:0] decode_fpga(input logic [3:0] opc);
    logic [3:0] r;
    r = opc % FPGA_COUNT;
    return r[1:0] + 2'h1;
  endfunction
endpackage

// file: core/reg_bus_if.sv
// Internal register access path between the serial front end and the register store.
`timescale 1ns/1ps
`default_nettype none
interface reg_bus_if;
  logic [7:0] addr;
  logic wr_stb;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport master(output addr, output wr_stb, output wdata, input rdata);
  modport target(input addr, input wr_stb, input wdata, output rdata);
endinterface
`default_nettype wire

// file: core/cfg_reg_store.sv
// Writable configuration words and the read multiplexer of the register file.
`timescale 1ns/1ps
`default_nettype none
module cfg_reg_store (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  reg_bus_if.target bus,
  input wire logic [15:0] lane_word,
  input wire logic [15:0] summary_word,
  input wire logic [15:0] temp_word,
  input wire logic [15:0] volt_word,
  input wire logic [15:0] idle_ver_word,
  input wire logic [15:0] sread_word,
  output logic [15:0] slot_en_q,
  output logic [15:0] align_q,
  output logic [15:0] cmd_q,
  output logic [15:0] erase_q,
  output logic [15:0] sdata_q,
  output logic [15:0] saddr_lo_q,
  output logic [15:0] sctrl_q
);
  import cfg_regs_pkg::*;

  // Undefined bits are never stored, so they always read back as zero.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_en_q <= RST_WORD;
      align_q <= RST_WORD;
      cmd_q <= RST_WORD;
      erase_q <= RST_WORD;
      sdata_q <= RST_WORD;
      saddr_lo_q <= RST_WORD;
      sctrl_q <= RST_WORD;
    end else if (ce && bus.wr_stb) begin
      case (bus.addr)
        OFF_SLOT_EN: slot_en_q <= bus.wdata & SLOT_EN_MASK; // [RULE_03]
        OFF_ALIGN: align_q <= bus.wdata & ALIGN_MASK; // [RULE_04]
        OFF_CMD: cmd_q <= bus.wdata & CMD_MASK; // [RULE_06] [RULE_09]
        OFF_ERASE: erase_q <= bus.wdata & ERASE_MASK; // [RULE_10]
        OFF_SDATA: sdata_q <= bus.wdata; // [RULE_11]
        OFF_SADDR_LO: saddr_lo_q <= bus.wdata; // [RULE_12]
        OFF_SCTRL: sctrl_q <= bus.wdata & SCTRL_MASK; // [RULE_12]
        default: ;
      endcase
    end
  end

  always_comb begin
    case (bus.addr)
      OFF_LANE: bus.rdata = lane_word;
      OFF_SUMMARY: bus.rdata = summary_word;
      OFF_SLOT_EN: bus.rdata = slot_en_q;
      OFF_ALIGN: bus.rdata = align_q;
      OFF_TEMP: bus.rdata = temp_word;
      OFF_VOLT: bus.rdata = volt_word;
      OFF_CMD: bus.rdata = cmd_q;
      OFF_ERASE: bus.rdata = erase_q;
      OFF_SDATA: bus.rdata = sdata_q;
      OFF_SADDR_LO: bus.rdata = saddr_lo_q;
      OFF_SCTRL: bus.rdata = sctrl_q;
      OFF_SREAD: bus.rdata = sread_word; // [RULE_15]
      OFF_IDLE_VER: bus.rdata = idle_ver_word; // [RULE_16]
      default: bus.rdata = RST_WORD;
    endcase
  end
endmodule
`default_nettype wire

// file: core/i2c_config_register_file.sv
// I2C slave front end, configuration command logic and status assembly of the register file.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01: Status 0 holds channel and lane up flags.
// RULE_02: Status 1 shows all-up and top slot.
// RULE_03: Config 0 holds five slot receive enables.
// RULE_04: Config 1 arms alignment, initialises transceivers.
// RULE_05: Host arms, pulses sync, then disarms.
// RULE_06: Command bits 10..9 select target FPGA.
// RULE_07: Opcode starts only on execute rising edge.
// RULE_08: Command bit 7 grants host SRAM writes.
// RULE_09: Opcode field decodes program, read, ident, erase.
// RULE_10: Erase block number in bits 9..0.
// RULE_11: Config 4 stages the SRAM write word.
// RULE_12: Config 5 and 6 form 22-bit address.
// RULE_13: Rising bit 15 writes SRAM word.
// RULE_14: Rising bit 14 reads SRAM word.
// RULE_15: Status 3 returns last SRAM read word.
// RULE_16: Status 2 gives idle flag and version.
// RULE_17: Host spaces programming opcodes ten minutes apart.
// RULE_18: Host waits 220 ms between erases.
// RULE_19: Control edges give one single-cycle pulse.
module i2c_config_register_file #(
  parameter logic [14:0] FW_VERSION = 15'h0001
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sync_in,
  input wire logic [cfg_regs_pkg::N_LANES-1:0] lane_up,
  input wire logic [cfg_regs_pkg::N_SLOTS-1:0] chan_up,
  input wire logic [15:0] die_temp,
  input wire logic [15:0] core_volt,
  input wire logic engine_busy,
  input wire logic [15:0] sram_rd_data,
  input wire logic sram_rd_valid,
  output logic [cfg_regs_pkg::N_SLOTS-1:0] slot_enable,
  output logic init_transceivers,
  output logic align_start,
  output logic [1:0] target_sel,
  output logic sram_host_wr_sel,
  output logic [cfg_regs_pkg::ERASE_W-1:0] erase_block,
  output logic op_start,
  output cfg_regs_pkg::op_class_t op_kind,
  output logic [1:0] op_fpga,
  output logic [3:0] op_code,
  output logic sram_wr_stb,
  output logic sram_rd_stb,
  output logic [cfg_regs_pkg::SRAM_ADDR_W-1:0] sram_addr,
  output logic [15:0] sram_wdata
);
  import cfg_regs_pkg::*;

  reg_bus_if bus ();

  logic [15:0] slot_en_w;
  logic [15:0] align_w;
  logic [15:0] cmd_w;
  logic [15:0] erase_w;
  logic [15:0] sdata_w;
  logic [15:0] saddr_lo_w;
  logic [15:0] sctrl_w;
  logic [15:0] lane_word;
  logic [15:0] summary_word;
  logic [15:0] idle_ver_word;
  logic [15:0] sread_q;

  // Pins from outside pass three flops; a level is taken once stages two and three agree.
  logic [2:0] pin_raw;
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_f_q;
  logic [2:0] pin_p_q;
  assign pin_raw = {sync_in, sda_in, scl_in};

  for (genvar g = 0; g < 3; g++) begin : g_pin
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pin_s1_q[g] <= PIN_IDLE[g];
        pin_s2_q[g] <= PIN_IDLE[g];
        pin_s3_q[g] <= PIN_IDLE[g];
        pin_f_q[g] <= PIN_IDLE[g];
        pin_p_q[g] <= PIN_IDLE[g];
      end else if (ce) begin
        pin_s1_q[g] <= pin_raw[g];
        pin_s2_q[g] <= pin_s1_q[g];
        pin_s3_q[g] <= pin_s2_q[g];
        if (pin_s2_q[g] == pin_s3_q[g]) begin
          pin_f_q[g] <= pin_s3_q[g];
        end
        pin_p_q[g] <= pin_f_q[g];
      end
    end
  end

  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_f = pin_f_q[0];
  assign sda_f = pin_f_q[1];
  assign scl_rise = scl_f & ~pin_p_q[0];
  assign scl_fall = ~scl_f & pin_p_q[0];
  assign start_ev = scl_f & pin_p_q[0] & pin_p_q[1] & ~sda_f;
  assign stop_ev = scl_f & pin_p_q[0] & ~pin_p_q[1] & sda_f;

  i2c_state_t st_q;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] sub_q;
  logic [7:0] wbuf_q;
  logic [7:0] tx_q;
  logic [7:0] lo_q;
  logic [7:0] nb;
  logic [15:0] wdata_q;
  logic rw_q;
  logic hi_q;
  logic mack_q;
  logic drv_q;
  logic wr_stb_q;
  logic load_now;

  // Read words go out high byte first; the low byte is frozen when the high byte loads.
  assign nb = hi_q ? bus.rdata[15:8] : lo_q;
  assign load_now = scl_fall & ~start_ev & ~stop_ev &
                    (((st_q == I2C_ACK_ADDR) & rw_q) | ((st_q == I2C_ACK_R) & ~mack_q));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= I2C_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      sub_q <= 8'h00;
      wbuf_q <= 8'h00;
      wdata_q <= RST_WORD;
      rw_q <= 1'b0;
      hi_q <= 1'b1;
      mack_q <= 1'b1;
      drv_q <= 1'b0;
      wr_stb_q <= 1'b0;
    end else if (ce) begin
      wr_stb_q <= 1'b0;
      // The sub-address steps on only after the strobe has used it, so a word lands where aimed.
      if (wr_stb_q) begin
        sub_q <= sub_q + 8'h01;
      end
      if (start_ev) begin
        st_q <= I2C_ADDR;
        cnt_q <= 4'h0;
        drv_q <= 1'b0;
        hi_q <= 1'b1;
      end else if (stop_ev) begin
        st_q <= I2C_IDLE;
        drv_q <= 1'b0;
      end else if (scl_rise) begin
        case (st_q)
          I2C_ADDR, I2C_SUB, I2C_WDATA: begin
            sh_q <= {sh_q[6:0], sda_f};
            cnt_q <= cnt_q + 4'h1;
          end
          I2C_ACK_R: mack_q <= sda_f;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (st_q)
          I2C_ADDR: begin
            if (cnt_q == BYTE_BITS) begin
              cnt_q <= 4'h0;
              if (sh_q[7:1] == BOARD_ADDR) begin
                drv_q <= 1'b1;
                rw_q <= sh_q[0];
                st_q <= I2C_ACK_ADDR;
              end else begin
                st_q <= I2C_IDLE;
              end
            end
          end
          I2C_SUB: begin
            if (cnt_q == BYTE_BITS) begin
              cnt_q <= 4'h0;
              sub_q <= sh_q;
              hi_q <= 1'b1;
              drv_q <= 1'b1;
              st_q <= I2C_ACK_SUB;
            end
          end
          I2C_WDATA: begin
            if (cnt_q == BYTE_BITS) begin
              cnt_q <= 4'h0;
              drv_q <= 1'b1;
              st_q <= I2C_ACK_W;
              if (hi_q) begin
                wbuf_q <= sh_q;
                hi_q <= 1'b0;
              end else begin
                wdata_q <= {wbuf_q, sh_q};
                wr_stb_q <= 1'b1;
                hi_q <= 1'b1;
              end
            end
          end
          I2C_ACK_ADDR, I2C_ACK_R: begin
            if (load_now) begin
              drv_q <= ~nb[7];
              cnt_q <= 4'h1;
              st_q <= I2C_RDATA;
              hi_q <= ~hi_q;
              if (!hi_q) begin
                sub_q <= sub_q + 8'h01;
              end
            end else if (st_q == I2C_ACK_ADDR) begin
              drv_q <= 1'b0;
              st_q <= I2C_SUB;
            end else begin
              st_q <= I2C_IDLE;
            end
          end
          I2C_ACK_SUB, I2C_ACK_W: begin
            drv_q <= 1'b0;
            st_q <= I2C_WDATA;
          end
          I2C_RDATA: begin
            if (cnt_q == BYTE_BITS) begin
              drv_q <= 1'b0;
              cnt_q <= 4'h0;
              st_q <= I2C_ACK_R;
            end else begin
              drv_q <= ~tx_q[7];
              cnt_q <= cnt_q + 4'h1;
            end
          end
          default: st_q <= I2C_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (ce) begin
      if (load_now) begin
        tx_q <= {nb[6:0], 1'b0};
        if (hi_q) begin
          lo_q <= bus.rdata[7:0];
        end
      end else if (scl_fall && st_q == I2C_RDATA) begin
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  assign bus.addr = sub_q;
  assign bus.wr_stb = wr_stb_q;
  assign bus.wdata = wdata_q;
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drv_q;

  cfg_reg_store u_store (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ce(ce),
    .bus(bus),
    .lane_word(lane_word),
    .summary_word(summary_word),
    .temp_word(die_temp),
    .volt_word(core_volt),
    .idle_ver_word(idle_ver_word),
    .sread_word(sread_q),
    .slot_en_q(slot_en_w),
    .align_q(align_w),
    .cmd_q(cmd_w),
    .erase_q(erase_w),
    .sdata_q(sdata_w),
    .saddr_lo_q(saddr_lo_w),
    .sctrl_q(sctrl_w)
  );

  // Status words; bits 11 and 10 of the lane word and upper summary bits read zero.
  assign lane_word = {chan_up[N_SLOTS-2:0], 2'b00, lane_up}; // [RULE_01]
  assign summary_word = {14'h0000, &chan_up, chan_up[N_SLOTS-1]}; // [RULE_02]

  logic op_pend_q;
  logic rd_pend_q;
  logic idle;
  assign idle = ~engine_busy & ~op_pend_q & ~rd_pend_q;
  assign idle_ver_word = {idle, FW_VERSION}; // [RULE_16]

  // Edge detection against last cycle's value; a held bit gives nothing more.
  logic [2:0] edge_src;
  logic [2:0] edge_prev_q;
  logic [2:0] edge_pulse;
  logic [3:0] opcode;
  assign edge_src = {sctrl_w[SWR_BIT], sctrl_w[SRD_BIT], cmd_w[EXEC_BIT]};
  assign edge_pulse = edge_src & ~edge_prev_q; // [RULE_19]
  assign opcode = cmd_w[OPC_LSB +: 4];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_prev_q <= 3'b000;
    end else if (ce) begin
      edge_prev_q <= edge_src;
    end
  end

  // An execute edge seen while busy or with an unused opcode is dropped, not queued.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_start <= 1'b0;
      op_kind <= OP_NONE;
      op_fpga <= 2'h0;
      op_code <= 4'h0;
    end else if (ce) begin
      op_start <= 1'b0;
      if (edge_pulse[0] && idle && decode_op(opcode) != OP_NONE) begin // [RULE_07]
        op_start <= 1'b1;
        op_kind <= decode_op(opcode); // [RULE_09]
        op_fpga <= decode_fpga(opcode);
        op_code <= opcode;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sram_wr_stb <= 1'b0;
      sram_rd_stb <= 1'b0;
    end else if (ce) begin
      sram_wr_stb <= edge_pulse[2]; // [RULE_13]
      sram_rd_stb <= edge_pulse[1]; // [RULE_14]
    end
  end

  // Pending flags cover the gap before the engine answers; a new set beats a clear.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
    end else if (ce) begin
      if (op_start) begin
        op_pend_q <= 1'b1;
      end else if (engine_busy) begin
        op_pend_q <= 1'b0;
      end
      if (sram_rd_stb) begin
        rd_pend_q <= 1'b1;
      end else if (sram_rd_valid) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sread_q <= RST_WORD;
    end else if (ce && sram_rd_valid) begin
      sread_q <= sram_rd_data; // [RULE_14] [RULE_15]
    end
  end

  // Alignment runs only while armed; the host disarms it after its sync pulse.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      align_start <= 1'b0;
    end else if (ce) begin
      align_start <= align_w[ALIGN_ARM_BIT] & pin_p_q[2] & ~pin_f_q[2]; // [RULE_04] [RULE_05]
    end
  end

  for (genvar s = 0; s < N_SLOTS; s++) begin : g_slot
    assign slot_enable[s] = slot_en_w[SLOT_EN_LSB + 2 * s]; // [RULE_03]
  end

  assign init_transceivers = align_w[INIT_BIT]; // [RULE_04]
  assign target_sel = cmd_w[TGT_LSB +: 2]; // [RULE_06]
  assign sram_host_wr_sel = cmd_w[SRAM_SEL_BIT]; // [RULE_08]
  assign erase_block = erase_w[ERASE_W-1:0]; // [RULE_10]
  assign sram_wdata = sdata_w; // [RULE_11]
  assign sram_addr = {sctrl_w[ADDR_HI_W-1:0], saddr_lo_w}; // [RULE_12]
endmodule
`default_nettype wire

// file: sim/cfg_regs_properties.sv
// Port-level assertions for the I2C configuration register file.
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_properties (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sync_in,
  input wire logic [cfg_regs_pkg::N_SLOTS-1:0] slot_enable,
  input wire logic [cfg_regs_pkg::SRAM_ADDR_W-1:0] sram_addr,
  input wire logic [1:0] target_sel,
  input wire logic op_start,
  input wire cfg_regs_pkg::op_class_t op_kind,
  input wire logic [1:0] op_fpga,
  input wire logic [3:0] op_code,
  input wire logic sram_wr_stb,
  input wire logic sram_rd_stb,
  input wire logic align_start
);
  import cfg_regs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  function automatic op_class_t kind_of(input logic [3:0] c);
    return c < 4'h3 ? OP_PROGRAM : c < 4'h6 ? OP_READ : c < 4'h9 ? OP_IDENT : OP_ERASE;
  endfunction
  sequence single_pulse(s);
    s ##1 !s;
  endsequence
  op_pulse_a: assert property (op_start |-> single_pulse(op_start))
    else $error("op_start lasted more than one cycle");
  op_decode_a: assert property (op_start |-> op_code < 4'hC && op_kind == kind_of(op_code))
    else $error("op_kind does not match op_code");
  op_fpga_a: assert property (op_start |-> 4'(op_fpga) == op_code % 4'h3 + 4'h1)
    else $error("op_fpga does not match op_code");
  op_hold_a: assert property (!op_start |-> $stable(op_code) && $stable(op_kind))
    else $error("operation fields changed without a start");
  wr_pulse_a: assert property (sram_wr_stb |-> single_pulse(sram_wr_stb))
    else $error("sram_wr_stb lasted more than one cycle");
  rd_pulse_a: assert property (sram_rd_stb |-> single_pulse(sram_rd_stb))
    else $error("sram_rd_stb lasted more than one cycle");
  align_pulse_a: assert property (align_start |-> !sync_in ##1 !align_start)
    else $error("align_start not a single pulse after sync fell");
  freeze_a: assert property (!ce |=> $stable(slot_enable) && $stable(sram_addr) && $stable(target_sel))
    else $error("state moved while clock enable was low");
endmodule
bind i2c_config_register_file cfg_regs_properties u_props (.sys_clk, .rst_n, .ce, .sync_in,
  .slot_enable, .sram_addr, .target_sel, .op_start, .op_kind, .op_fpga, .op_code,
  .sram_wr_stb, .sram_rd_stb, .align_start);
`default_nettype wire

// file: sim/i2c_host_model.sv
// Behavioural I2C host issuing 16-bit register writes and reads, high byte first.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull_low
);
  import cfg_regs_pkg::*;
  initial begin
    scl = 1'b1;
    sda_pull_low = 1'b0;
  end
  // SDA moves three clocks after SCL falls, so the filtered pins never change together.
  task automatic bit_io(input logic b, output logic r);
    repeat (3) @(negedge sys_clk);
    sda_pull_low = !b;
    repeat (7) @(negedge sys_clk);
    scl = 1'b1;
    repeat (10) @(negedge sys_clk);
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic start_cond;
    repeat (3) @(negedge sys_clk);
    sda_pull_low = 1'b0;
    repeat (7) @(negedge sys_clk);
    scl = 1'b1;
    repeat (10) @(negedge sys_clk);
    sda_pull_low = 1'b1;
    repeat (10) @(negedge sys_clk);
    scl = 1'b0;
  endtask
  task automatic stop_cond;
    repeat (3) @(negedge sys_clk);
    sda_pull_low = 1'b1;
    repeat (7) @(negedge sys_clk);
    scl = 1'b1;
    repeat (10) @(negedge sys_clk);
    sda_pull_low = 1'b0;
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic xbyte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                       output logic ack_out);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ack_in, ack_out);
  endtask
  task automatic write_reg(input logic [7:0] sub, input logic [15:0] data);
    logic [7:0] rx;
    logic ack;
    start_cond();
    xbyte({BOARD_ADDR, 1'b0}, 1'b1, rx, ack);
    xbyte(sub, 1'b1, rx, ack);
    xbyte(data[15:8], 1'b1, rx, ack);
    xbyte(data[7:0], 1'b1, rx, ack);
    stop_cond();
  endtask
  task automatic read_reg(input logic [7:0] sub, output logic [15:0] data);
    logic [7:0] hi;
    logic [7:0] lo;
    logic ack;
    start_cond();
    xbyte({BOARD_ADDR, 1'b0}, 1'b1, hi, ack);
    xbyte(sub, 1'b1, hi, ack);
    start_cond();
    xbyte({BOARD_ADDR, 1'b1}, 1'b1, hi, ack);
    xbyte(8'hFF, 1'b0, hi, ack);
    xbyte(8'hFF, 1'b1, lo, ack);
    stop_cond();
    data = {hi, lo};
  endtask
endmodule
`default_nettype wire

// file: sim/tb_i2c_config_register_file.sv
// Self-checking bench for the I2C configuration register file.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_config_register_file;
  import cfg_regs_pkg::*;
  typedef struct {logic [7:0] sub; logic [15:0] wdata; logic [15:0] exp;} row_t;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic sync_in = 1'b0;
  logic engine_busy = 1'b0;
  logic sram_rd_valid = 1'b0;
  logic [N_LANES-1:0] lane_up = 10'h2A5;
  logic [N_SLOTS-1:0] chan_up = 5'h17;
  logic [15:0] die_temp = 16'h1357;
  logic [15:0] core_volt = 16'h2468;
  logic [15:0] sram_rd_data = 16'h0000;
  wire logic scl, sda_pull_low, sda_line, sda_out, sda_oe_n;
  logic [N_SLOTS-1:0] slot_enable;
  logic init_transceivers, align_start, sram_host_wr_sel, op_start, sram_wr_stb, sram_rd_stb;
  logic [1:0] target_sel, op_fpga, fpga_seen;
  logic [ERASE_W-1:0] erase_block;
  op_class_t op_kind, kind_seen;
  logic [3:0] op_code, code_seen;
  logic [SRAM_ADDR_W-1:0] sram_addr, addr_seen;
  logic [15:0] sram_wdata, wdata_seen;
  int error_cnt = 0, samples_checked = 0, op_cnt = 0, wr_cnt = 0, rd_cnt = 0, align_cnt = 0;
  int busy_left = 0;
  logic rd_req = 1'b0;
  row_t rows [14] = '{
    '{OFF_SLOT_EN, 16'hFFFF, 16'h5540}, '{OFF_ALIGN, 16'hFFFF, 16'h000A},
    '{OFF_CMD, 16'h06F8, 16'h06F8}, '{OFF_ERASE, 16'hFFFF, 16'h03FF},
    '{OFF_SDATA, 16'hA5C3, 16'hA5C3}, '{OFF_SADDR_LO, 16'h1234, 16'h1234},
    '{OFF_SCTRL, 16'h3FFF, 16'h003F}, '{8'h0C, 16'hFFFF, 16'h0000},
    '{OFF_LANE, 16'hFFFF, 16'h72A5}, '{OFF_SUMMARY, 16'hFFFF, 16'h0001},
    '{OFF_TEMP, 16'h0000, 16'h1357}, '{OFF_VOLT, 16'h0000, 16'h2468},
    '{OFF_SREAD, 16'hFFFF, 16'h0000}, '{OFF_IDLE_VER, 16'h0000, 16'h8001}};
  // Open-drain SDA with a pull-up: low when either party pulls it.
  assign sda_line = !(sda_pull_low || !sda_oe_n);
  always #50 sys_clk = ~sys_clk;
  i2c_host_model host (.sys_clk, .sda_line, .scl, .sda_pull_low);
  i2c_config_register_file uut (.sys_clk, .rst_n, .ce, .scl_in(scl), .sda_in(sda_line),
    .sda_out, .sda_oe_n, .sync_in, .lane_up, .chan_up, .die_temp, .core_volt, .engine_busy,
    .sram_rd_data, .sram_rd_valid, .slot_enable, .init_transceivers, .align_start,
    .target_sel, .sram_host_wr_sel, .erase_block, .op_start, .op_kind, .op_fpga, .op_code,
    .sram_wr_stb, .sram_rd_stb, .sram_addr, .sram_wdata);
  // Engine and SRAM stand-in; its busy time stands for the host's long waits between
  // ROM operations, scaled down so the run stays short.
  always @(negedge sys_clk) begin
    if (op_start) begin
      op_cnt++;
      code_seen = op_code;
      kind_seen = op_kind;
      fpga_seen = op_fpga;
      busy_left = 1500;
    end
    if (sram_wr_stb) begin
      wr_cnt++;
      addr_seen = sram_addr;
      wdata_seen = sram_wdata;
    end
    rd_cnt += int'(sram_rd_stb);
    align_cnt += int'(align_start);
    engine_busy = busy_left != 0;
    busy_left = busy_left > 0 ? busy_left - 1 : 0;
    // The SRAM answers one cycle after the strobe, as a real memory would.
    sram_rd_valid = rd_req;
    sram_rd_data = rd_req ? 16'hC0DE : ~sram_rd_data;
    rd_req = sram_rd_stb;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [7:0] s, input logic [15:0] e);
    logic [15:0] v;
    host.read_reg(s, v);
    check($sformatf("sub_%h", s), v, e);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_idle;
    for (int n = 0; engine_busy; n++) begin
      if (n > 3000) begin
        error_cnt++;
        summarize();
      end
      @(negedge sys_clk);
    end
  endtask
  task automatic pulse_sync;
    sync_in = 1'b1;
    repeat (12) @(negedge sys_clk);
    sync_in = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask
  initial begin
    logic [15:0] v;
    int base;
    op_class_t k;
    repeat (12) @(negedge sys_clk);
    check("oe_n_reset", sda_oe_n, 1'b1);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      host.write_reg(rows[i].sub, rows[i].wdata);
      rd_chk(rows[i].sub, rows[i].exp);
    end
    check("slot_enable", slot_enable, 5'h1F);
    check("init", init_transceivers, 1'b1);
    check("sram_sel", sram_host_wr_sel, 1'b1);
    check("erase_block", erase_block, 10'h3FF);
    check("sram_addr", sram_addr, 22'h3F1234);
    check("sram_wdata", sram_wdata, 16'hA5C3);
    chan_up = 5'h1F;
    rd_chk(OFF_SUMMARY, 16'h0003);
    for (int c = 0; c < 13; c++) begin
      v = {5'h00, 2'(c % 3 + 1), 1'b1, 1'b0, 4'(c), 3'h0};
      base = op_cnt;
      host.write_reg(OFF_CMD, v);
      if (c == 9) rd_chk(OFF_IDLE_VER, 16'h0001);
      host.write_reg(OFF_CMD, v);
      check("op_count", op_cnt - base, c < 12);
      check("target_sel", target_sel, c % 3 + 1);
      k = c < 3 ? OP_PROGRAM : c < 6 ? OP_READ : c < 9 ? OP_IDENT : OP_ERASE;
      if (c < 12) begin
        check("op_code", code_seen, c);
        check("op_kind", kind_seen, k);
        check("op_fpga", fpga_seen, c % 3 + 1);
      end
      wait_idle();
      host.write_reg(OFF_CMD, v & 16'hFEFF);
    end
    check("sram_sel_off", sram_host_wr_sel, 1'b0);
    host.write_reg(OFF_SDATA, 16'hBEEF);
    host.write_reg(OFF_SADDR_LO, 16'h0042);
    host.write_reg(OFF_SCTRL, 16'h8015);
    check("wr_count", wr_cnt, 1);
    check("wr_addr", addr_seen, 22'h150042);
    check("wr_data", wdata_seen, 16'hBEEF);
    host.write_reg(OFF_SCTRL, 16'h4015);
    check("rd_count", rd_cnt, 1);
    rd_chk(OFF_SREAD, 16'hC0DE);
    rd_chk(OFF_IDLE_VER, 16'h8001);
    host.write_reg(OFF_ALIGN, 16'h0008);
    check("init_off", init_transceivers, 1'b0);
    pulse_sync();
    check("align_armed", align_cnt, 1);
    host.write_reg(OFF_ALIGN, 16'h0000);
    pulse_sync();
    check("align_disarmed", align_cnt, 1);
    ce = 1'b0;
    repeat (6) @(negedge sys_clk);
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("slot_en_reset", slot_enable, 5'h00);
    check("addr_reset", sram_addr, 22'h000000);
    rst_n = 1'b1;
    rd_chk(OFF_ERASE, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
